//--- logic/seq_pkg.sv
// Shared constants and types for the program sequencer
package seq_pkg;
    // Address counter width and stack depth
    localparam int ADDR_W      = 13;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = 3;
    // Phases per instruction cycle
    localparam int PHASES      = 4;
    localparam logic [1:0] PH_FETCH = 2'h3;
    // Data-memory offset of the low byte
    localparam logic [7:0] LOWBYTE_ADDR = 8'h06;
    // Vector addresses
    localparam logic [12:0] VEC_RESET = 13'h0000;
    localparam logic [12:0] VEC_EXT   = 13'h0004;
    localparam logic [12:0] VEC_TMR0  = 13'h0008;
    localparam logic [12:0] VEC_TMR1  = 13'h000c;
    localparam logic [12:0] VEC_MULTI = 13'h0010;
    localparam logic [12:0] VEC_ADC   = 13'h0014;
    localparam logic [12:0] VEC_TOUCH = 13'h0018;
    // Wake-up delays in system clock periods
    localparam int WAKE_LONG  = 1024;
    localparam int WAKE_SHORT = 2;
    localparam logic [10:0] WAKE_LONG_CNT  = 11'(WAKE_LONG);
    localparam logic [10:0] WAKE_SHORT_CNT = 11'(WAKE_SHORT);

    // Control-transfer command from the decoder
    typedef enum logic [2:0] {
        CMD_NONE, CMD_JUMP, CMD_CALL, CMD_RET, CMD_SKIP
    } seq_cmd_t;

    // Decoder request bundle
    typedef struct packed {
        seq_cmd_t    cmd;
        logic [12:0] target;
    } seq_req_t;

    // Register port bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;
endpackage

//--- logic/phase_gen.sv
// Four-phase instruction cycle generator
`timescale 1ns/10ps
module phase_gen (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    // Hold while starting up
    input  wire logic       hold_in,
    // Phase outputs
    output logic [1:0]      phase_out,
    output logic [3:0]      phase_onehot_out
);
    // Phase counter; frozen at phase 0 while held
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_out <= 2'h0;
        end else if (hold_in) begin
            phase_out <= 2'h0;
        end else begin
            phase_out <= phase_out + 2'h1;
        end
    end

    // Non-overlapping one-hot phases
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_onehot_out <= 4'h1;
        end else if (hold_in) begin
            phase_onehot_out <= 4'h1;
        end else begin
            phase_onehot_out <= {phase_onehot_out[2:0],
                                 phase_onehot_out[3]};
        end
    end
endmodule

//--- logic/ret_stack.sv
// Eight-level return address stack, registered read
`timescale 1ns/10ps
module ret_stack #(
    parameter int DEPTH = seq_pkg::STACK_DEPTH,
    parameter int AW    = seq_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic          mclk_in,
    input  wire logic          sys_rst_in,
    // Push and pop
    input  wire logic          push_in,
    input  wire logic          pop_in,
    input  wire logic [AW-1:0] push_data_in,
    // Top entry and fill state
    output logic [AW-1:0]      top_out,
    output logic               full_out
);
    localparam int PW = $clog2(DEPTH);
    logic [AW-1:0] mem [DEPTH];
    logic [PW-1:0] sp;
    logic [PW:0]   count;

    // Circular store; overflow silently drops the oldest entry
    always_ff @(posedge mclk_in) begin
        if (push_in) begin
            mem[sp] <= push_data_in;
        end
    end

    // Pointer and occupancy
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sp    <= '0;
            count <= '0;
        end else if (push_in) begin
            sp <= sp + PW'(1);
            if (count != (PW+1)'(DEPTH)) begin
                count <= count + (PW+1)'(1);
            end
        end else if (pop_in) begin
            sp <= sp - PW'(1);
            if (count != '0) begin
                count <= count - (PW+1)'(1);
            end
        end
    end

    // Registered top-of-stack read
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            top_out  <= '0;
            full_out <= 1'b0;
        end else begin
            top_out  <= push_in ? push_data_in : mem[sp - PW'(1)];
            full_out <= (count == (PW+1)'(DEPTH));
        end
    end
endmodule

//--- logic/program_sequencer.sv
// Instruction sequencer: phases, pipeline, address counter, wake delay
`timescale 1ns/10ps
module program_sequencer (
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              sys_rst_in,
    // Program memory
    input  wire logic [15:0]       rom_data_in,
    output logic [12:0]            rom_addr_out,
    output logic                   rom_rd_out,
    // Decoder side
    input  wire seq_pkg::seq_req_t dec_req_in,
    input  wire logic              skip_met_in,
    output logic [15:0]            instr_out,
    output logic                   instr_valid_out,
    output logic                   exec_strobe_out,
    // Interrupt acknowledge
    input  wire logic              irq_req_in,
    input  wire logic [2:0]        irq_src_in,
    output logic                   irq_ack_out,
    // Register port
    input  wire seq_pkg::reg_req_t reg_in,
    output logic [7:0]             reg_rdata_out,
    // Power management
    input  wire logic              wake_in,
    input  wire logic              osc_rc_in,
    input  wire logic              short_start_in,
    output logic                   running_out,
    // Current instruction cycle phase
    output logic [1:0]             phase_out
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [12:0] pc;
    logic [12:0] next_pc;
    logic [1:0]  phase;
    logic [3:0]  phase_oh;
    logic        flush;
    logic        next_flush;
    logic        holding;
    logic [10:0] wake_cnt;
    logic        push;
    logic        pop;
    logic [12:0] stack_top;
    logic        stack_full;
    logic        lowbyte_wr;
    logic        end_cycle;
    logic        take_irq;
    logic [7:0]  lowbyte_wdata;
    logic        lowbyte_pend;
    logic [2:0]  irq_src;

    // Vector lookup by interrupt source number
    function automatic logic [12:0] vector_of(input logic [2:0] src);
        unique case (src)
            3'h1:    vector_of = seq_pkg::VEC_EXT;
            3'h2:    vector_of = seq_pkg::VEC_TMR0;
            3'h3:    vector_of = seq_pkg::VEC_TMR1;
            3'h4:    vector_of = seq_pkg::VEC_MULTI;
            3'h5:    vector_of = seq_pkg::VEC_ADC;
            3'h6:    vector_of = seq_pkg::VEC_TOUCH;
            default: vector_of = seq_pkg::VEC_RESET;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Phase generation
    phase_gen u_phase (
        .mclk_in          (mclk_in),
        .sys_rst_in       (sys_rst_in),
        .hold_in          (holding),
        .phase_out        (phase),
        .phase_onehot_out (phase_oh)
    );

    assign end_cycle = ~holding & (phase == seq_pkg::PH_FETCH);
    // Low-byte write decode
    assign lowbyte_wr = reg_in.wr & (reg_in.addr == seq_pkg::LOWBYTE_ADDR);
    // Interrupts are held off by a full stack and during dummy cycles
    assign take_irq = end_cycle & ~flush
                    & ~stack_full & (dec_req_in.cmd == seq_pkg::CMD_NONE)
                    & ~lowbyte_pend & irq_req_in;

    ////////////////////////////////////////////////////////////////////
    // Wake-up start-up delay
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            holding  <= 1'b0;
            wake_cnt <= 11'h000;
        end else if (wake_in && !holding) begin
            holding <= 1'b1;
            // Crystal always uses the long wait
            if (osc_rc_in && short_start_in) begin
                wake_cnt <= seq_pkg::WAKE_SHORT_CNT - 11'h001;
            end else begin
                wake_cnt <= seq_pkg::WAKE_LONG_CNT - 11'h001;
            end
        end else if (holding) begin
            if (wake_cnt == 11'h000) begin
                holding <= 1'b0;
            end else begin
                wake_cnt <= wake_cnt - 11'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pending low-byte write, applied at the next cycle boundary
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lowbyte_pend  <= 1'b0;
            lowbyte_wdata <= 8'h00;
        end else if (lowbyte_wr) begin
            lowbyte_pend  <= 1'b1;
            lowbyte_wdata <= reg_in.wdata;
        end else if (end_cycle) begin
            lowbyte_pend <= 1'b0;
        end
    end

    assign irq_src = irq_src_in;

    ////////////////////////////////////////////////////////////////////
    // Next counter value and pipeline flush
    always_comb begin
        next_pc    = pc + 13'h0001;
        next_flush = 1'b0;
        push       = 1'b0;
        pop        = 1'b0;
        if (lowbyte_pend) begin
            // Short jump stays in the current page
            next_pc    = {pc[12:8], lowbyte_wdata};
            next_flush = 1'b1;
        end else if (flush) begin
            // Dummy cycle still fetches the target
            next_pc = pc + 13'h0001;
        end else if (take_irq) begin
            next_pc    = vector_of(irq_src);
            next_flush = 1'b1;
            push       = 1'b1;
        end else begin
            unique case (dec_req_in.cmd)
                seq_pkg::CMD_JUMP: begin
                    next_pc    = dec_req_in.target;
                    next_flush = 1'b1;
                end
                seq_pkg::CMD_CALL: begin
                    next_pc    = dec_req_in.target;
                    next_flush = 1'b1;
                    push       = 1'b1;
                end
                seq_pkg::CMD_RET: begin
                    next_pc    = stack_top;
                    next_flush = 1'b1;
                    pop        = 1'b1;
                end
                seq_pkg::CMD_SKIP: begin
                    // Prefetched word is dropped only when the skip is met, fetch goes on
                    next_flush = skip_met_in;
                end
                default: begin
                    next_pc = pc + 13'h0001;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Return stack
    ret_stack u_stack (
        .mclk_in      (mclk_in),
        .sys_rst_in   (sys_rst_in),
        .push_in      (push & end_cycle),
        .pop_in       (pop & end_cycle),
        .push_data_in (pc),
        .top_out      (stack_top),
        .full_out     (stack_full)
    );

    ////////////////////////////////////////////////////////////////////
    // Address counter; reset loads the reset vector
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pc    <= seq_pkg::VEC_RESET;
            flush <= 1'b1;
        end else if (end_cycle) begin
            pc    <= next_pc;
            flush <= next_flush;
        end
    end

    // Fetch: word latched while the previous one executes
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            instr_out       <= 16'h0000;
            instr_valid_out <= 1'b0;
        end else if (end_cycle) begin
            instr_out       <= rom_data_in;
            instr_valid_out <= ~next_flush;
        end
    end

    // Program memory address follows the counter
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rom_addr_out <= 13'h0000;
            rom_rd_out   <= 1'b0;
        end else begin
            rom_addr_out <= end_cycle ? next_pc : pc;
            rom_rd_out   <= ~holding & (phase == 2'h2);
        end
    end

    // Strobes and status
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            exec_strobe_out <= 1'b0;
            irq_ack_out     <= 1'b0;
            running_out     <= 1'b0;
            phase_out       <= 2'h0;
        end else begin
            exec_strobe_out <= end_cycle & ~flush;
            irq_ack_out     <= take_irq;
            // Low exactly while the wait holds, so it follows holding's next
            running_out     <= ~((wake_in & ~holding)
                               | (holding & (wake_cnt != 11'h000)));
            phase_out       <= phase;
        end
    end

    // Register read returns the low byte one cycle later
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_in.rd && reg_in.addr == seq_pkg::LOWBYTE_ADDR) begin
            reg_rdata_out <= pc[7:0];
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end
endmodule

//--- tb/program_sequencer_chk.sv
// Port-level assertions for the program sequencer
`timescale 1ns/10ps
module program_sequencer_chk (
    // Clock and reset
    input wire logic              mclk_in,
    input wire logic              sys_rst_in,
    // Watched ports
    input wire logic [12:0]       rom_addr_out,
    input wire logic              rom_rd_out,
    input wire logic              exec_strobe_out,
    input wire logic              irq_ack_out,
    input wire seq_pkg::reg_req_t reg_in,
    input wire logic [7:0]        reg_rdata_out,
    input wire logic              osc_rc_in,
    input wire logic              short_start_in,
    input wire logic              running_out,
    input wire logic [1:0]        phase_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////
    // One fetch and one execute per four clocks
    chk_fetch_gap: assert property (rom_rd_out |=> !rom_rd_out [*3])
        else $error("fetch strobes closer than four clocks");
    chk_exec_gap: assert property (exec_strobe_out |=> !exec_strobe_out [*3])
        else $error("execute strobes closer than four clocks");
    chk_phase_step: assert property (running_out && $past(running_out)
        && $past(running_out, 2) |-> phase_out == $past(phase_out) + 2'h1)
        else $error("phase did not advance by one");
    // Read data stand only after a read strobe
    chk_rdata_idle: assert property (!$past(reg_in.rd) |-> reg_rdata_out == 8'h00)
        else $error("read data shown without a read");
    // Acknowledge is a pulse, then a vector fetch
    chk_ack_pulse: assert property (irq_ack_out |=> !irq_ack_out)
        else $error("acknowledge longer than one clock");
    chk_ack_vector: assert property (irq_ack_out |-> ##[1:8] (rom_rd_out
        && rom_addr_out[12:5] == 8'h00 && rom_addr_out[1:0] == 2'h0))
        else $error("no vector fetch after acknowledge");
    // Start-up wait blocks fetching; length follows the option
    chk_wait_idle: assert property (!running_out ##1 !running_out |-> !rom_rd_out)
        else $error("fetch during start-up wait");
    chk_long_wait: assert property ($fell(running_out) && !osc_rc_in
        |-> !running_out [*8])
        else $error("crystal start-up wait too short");
    chk_short_wait: assert property ($fell(running_out) && osc_rc_in
        && short_start_in |-> ##[1:4] running_out)
        else $error("short start-up wait too long");
endmodule
bind program_sequencer program_sequencer_chk chk_i (
    .mclk_in, .sys_rst_in, .rom_addr_out, .rom_rd_out,
    .exec_strobe_out, .irq_ack_out, .reg_in, .reg_rdata_out,
    .osc_rc_in, .short_start_in, .running_out, .phase_out
);

//--- tb/rom_model.sv
// Behavioural program memory answering the fetch address
`timescale 1ns/10ps
module rom_model (
    // Clock
    input  wire logic        mclk_in,
    // Fetch port
    input  wire logic        rd_in,
    input  wire logic [12:0] addr_in,
    output logic [15:0]      data_out
);
    logic [15:0] last;
    // Remember the last word driven
    always_ff @(posedge mclk_in) begin
        if (rd_in) begin
            last <= {3'h5, addr_in};
        end
    end
    // Idle bus shows the inverse so a stale sample never matches
    assign data_out = rd_in ? {3'h5, addr_in} : ~last;
endmodule

//--- tb/program_sequencer_tb.sv
// Self-checking bench for the program sequencer
`timescale 1ns/10ps
module program_sequencer_tb;
    typedef struct {
        seq_pkg::seq_cmd_t cmd;
        logic [12:0]       tgt;
        logic              skp;
        logic              irq;
        logic [2:0]        src;
        int                sel;
        int                ex;
        int                ak;
    } row_t;
    logic              mclk_in, sys_rst_in, skip_met_in, irq_req_in;
    logic              wake_in, osc_rc_in, short_start_in, rom_rd_out;
    logic              instr_valid_out, exec_strobe_out, irq_ack_out;
    logic              running_out;
    logic [15:0]       rom_data_in, instr_out;
    logic [12:0]       rom_addr_out, saved, a0, a1, a2;
    logic [2:0]        irq_src_in;
    logic [7:0]        reg_rdata_out;
    logic [1:0]        phase_out;
    seq_pkg::seq_req_t dec_req_in;
    seq_pkg::reg_req_t reg_in;
    int                n_fail, checked, ne, na, n;
    row_t              r;
    // Jump with page carry, call, plain, return, skip met and not met
    row_t rows[6] = '{
        '{seq_pkg::CMD_JUMP, 13'h00ff, 1'b0, 1'b0, 3'h0, 0, 1, 0},
        '{seq_pkg::CMD_CALL, 13'h1f00, 1'b0, 1'b0, 3'h0, 0, 1, 0},
        '{seq_pkg::CMD_NONE, 13'h0000, 1'b0, 1'b0, 3'h0, 1, 2, 0},
        '{seq_pkg::CMD_RET,  13'h0000, 1'b0, 1'b0, 3'h0, 2, 1, 0},
        '{seq_pkg::CMD_SKIP, 13'h0000, 1'b1, 1'b0, 3'h0, 3, 1, 0},
        '{seq_pkg::CMD_SKIP, 13'h0000, 1'b0, 1'b0, 3'h0, 3, 2, 0}};
    program_sequencer dut (.mclk_in, .sys_rst_in, .rom_data_in,
        .rom_addr_out, .rom_rd_out, .dec_req_in, .skip_met_in, .instr_out,
        .instr_valid_out, .exec_strobe_out, .irq_req_in, .irq_src_in,
        .irq_ack_out, .reg_in, .reg_rdata_out, .wake_in, .osc_rc_in,
        .short_start_in, .running_out, .phase_out);
    rom_model rom (.mclk_in, .rd_in(rom_rd_out), .addr_in(rom_addr_out),
        .data_out(rom_data_in));
    ////////////////////////////////////////
    task automatic end_of_test();
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask
    // Wait for a phase-3 take edge; pre-edge values are what counts
    task automatic take(output logic [12:0] a);
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk_in);
            ne += int'(exec_strobe_out === 1'b1);
            na += int'(irq_ack_out === 1'b1);
            if (rom_rd_out === 1'b1) begin
                a = rom_addr_out;
                return;
            end
        end
        n_fail++;
        end_of_test();
    endtask
    // Hold a request over one cycle, then watch the two after it
    task automatic run(input row_t q);
        take(a0);
        dec_req_in <= '{q.cmd, q.tgt};
        skip_met_in <= q.skp;
        irq_req_in <= q.irq;
        irq_src_in <= q.src;
        take(a0);
        dec_req_in <= '{seq_pkg::CMD_NONE, 13'h0000};
        irq_req_in <= 1'b0;
        ne = 0;
        na = 0;
        take(a1);
        if (q.sel == 0) chk(16'(a1), 16'(q.tgt));
        if (q.sel == 1) chk(instr_out, {3'h5, a0});
        if (q.sel == 1) chk(16'(a1), 16'(a0 + 13'h1));
        if (q.sel == 2) chk(16'(a1), 16'(saved));
        chk(16'(instr_valid_out), 16'(q.ex == 2));
        if (q.cmd == seq_pkg::CMD_CALL) saved = a0;
        take(a2);
        chk(16'(a2), 16'(a1 + 13'h1));
        if (q.ex >= 0) chk(16'(ne), 16'(q.ex));
        chk(16'(na), 16'(q.ak));
    endtask
    ////////////////////////////////////////
    // Free-running system clock, 100 ns period
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    // Main sequence
    initial begin
        {sys_rst_in, skip_met_in, irq_req_in, wake_in} = 4'h8;
        {osc_rc_in, short_start_in, irq_src_in} = 5'h00;
        dec_req_in = '{seq_pkg::CMD_NONE, 13'h0000};
        reg_in = '0;
        n_fail = 0;
        checked = 0;
        ne = 0;
        na = 0;
        saved = 13'h0000;
        repeat (20) @(posedge mclk_in);
        chk({running_out, instr_valid_out, 1'b0, rom_addr_out}, 16'h0);
        sys_rst_in <= 1'b0;
        take(a0);
        chk(16'(a0), 16'(seq_pkg::VEC_RESET));
        foreach (rows[i]) run(rows[i]);
        // Every interrupt source, each serviced and returned from
        for (int s = 1; s < 7; s++) begin
            r = '{seq_pkg::CMD_NONE, 13'(s * 4), 1'b0, 1'b1, 3'(s), 0, -1, 1};
            run(r);
            r = '{seq_pkg::CMD_RET, 13'h0, 1'b0, 1'b0, 3'h0, 3, -1, 0};
            run(r);
        end
        // Low-byte write, then a read back to back; the write is pending
        take(a0);
        reg_in <= '{seq_pkg::LOWBYTE_ADDR, 8'h5a, 1'b1, 1'b0};
        @(posedge mclk_in);
        reg_in <= '{seq_pkg::LOWBYTE_ADDR, 8'h00, 1'b0, 1'b1};
        @(posedge mclk_in);
        reg_in <= '0;
        @(posedge mclk_in);
        chk(16'(reg_rdata_out), 16'((a0 + 13'h1) & 13'h00ff));
        take(a1);
        take(a2);
        chk(16'(a2), {3'h0, a1[12:8], 8'h5a});
        // Start-up wait for each clock source and option
        for (int i = 0; i < 4; i++) begin
            take(a0);
            {osc_rc_in, short_start_in} <= 2'(i);
            wake_in <= 1'b1;
            @(posedge mclk_in);
            wake_in <= 1'b0;
            n = 0;
            for (int k = 0; k < 3000; k++) begin
                @(posedge mclk_in);
                if (running_out !== 1'b1) n++;
                else if (n > 0) break;
            end
            chk(16'(n), (i == 3) ? 16'h0002 : 16'h0400);
        end
        end_of_test();
    end
endmodule
